// ==== design/ocd_regs.svh ====
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// Register indices; byte address is four times the index
`define OCD_IDX_DRIVER 14'h0707
`define OCD_IDX_DIVIDE 14'h070C
`define OCD_IDX_WIDTH 14'h0710
`define OCD_IDX_STATUS 14'h0711

// Reset values
`define OCD_RST_DRIVER 16'h0000
`define OCD_RST_DIVIDE 32'h00000002
`define OCD_RST_WIDTH 32'h00000002
`define OCD_RST_PAD_ONEHOT 8'h01

// Driver word field positions
`define OCD_PAD_MSB 14
`define OCD_PAD_LSB 12
`define OCD_BIAS_MSB 11
`define OCD_BIAS_LSB 8
`define OCD_LEVEL_MSB 7
`define OCD_LEVEL_LSB 4
`define OCD_CM_MSB 3
`define OCD_CM_LSB 0

// Field codes
`define OCD_BIAS_ON_CODE 4'h1
`define OCD_CM_DEFAULT 4'h0
`define OCD_MIN_WIDTH 32'h00000002

`endif

// ==== design/ocd_pkg.sv ====
package ocd_pkg;

  // Settings handed to the analog driver
  typedef struct packed {
    logic [7:0] pad_regulator_select;
    logic bias_resistor_enable;
    logic [3:0] regulator_level;
    logic [3:0] common_mode_level;
  } ocd_drive_type;

  // One APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ocd_apb_req_type;

endpackage

// ==== design/ocd_divider.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "ocd_regs.svh"
// Functional notes
// - Divide ratio sets output period in cycles
// - Ratio one forwards synthesizer clock unchanged
// - Pad regulator select decoded to eight codes
// - Bias resistor on only for code 0001
// - Regulator level field drives regulator code
// - Common mode field, ignored in CMOS
// - High time in half cycles from width
module ocd_divider
  import ocd_pkg::*;
#(
  parameter int CNT_W = 32
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire ocd_apb_req_type apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cmos_format,
  output ocd_drive_type drive_settings,
  output logic clock_out_positive,
  output logic clock_out_negative
);

  // Elaboration check on the counter width
  if (CNT_W < 2 || CNT_W > 32)
  begin : g_bad_cnt_w
    $error("CNT_W must be 2..32");
  end

  localparam logic [15:0] ADDR_DRIVER = {`OCD_IDX_DRIVER, 2'b00};
  localparam logic [15:0] ADDR_DIVIDE = {`OCD_IDX_DIVIDE, 2'b00};
  localparam logic [15:0] ADDR_WIDTH = {`OCD_IDX_WIDTH, 2'b00};
  localparam logic [15:0] ADDR_STATUS = {`OCD_IDX_STATUS, 2'b00};

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // Clamp width into 2 .. 2*div-1 half cycles
  function automatic logic [32:0] clamp_width(input logic [31:0] div, input logic [31:0] w);
    logic [32:0] hi;
    hi = {div, 1'b0} - 33'h000000001;
    if (w < `OCD_MIN_WIDTH) return {1'b0, `OCD_MIN_WIDTH};
    if ({1'b0, w} > hi) return hi;
    return {1'b0, w};
  endfunction

  logic [15:0] driver_analog_settings_reg, driver_analog_settings_next;
  logic [31:0] clock_divide_ratio_reg, clock_divide_ratio_next;
  logic [31:0] pulse_width_reg, pulse_width_next;
  logic access;
  logic mapped;

  // Divider state: ratio and width latched per period
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [31:0] act_div_reg, act_div_next;
  logic [33-1:0] act_wid_reg, act_wid_next;
  logic bypass_reg, bypass_next;
  logic full_reg, full_next;
  logic half_reg, half_next;
  logic boundary;

  // Output halves: one flop per clock edge, output is their XOR
  logic rise_half_reg, rise_half_next;
  logic fall_half_reg, fall_half_next;

  // Zero-wait APB slave decode
  assign access = apb_req.psel && apb_req.penable;
  assign pready = 1'b1;
  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h00000000;
    unique case (apb_req.paddr)
      ADDR_DRIVER: prdata = {16'h0000, driver_analog_settings_reg};
      ADDR_DIVIDE: prdata = clock_divide_ratio_reg;
      ADDR_WIDTH: prdata = pulse_width_reg;
      ADDR_STATUS: prdata = {30'h00000000, bypass_reg, clock_out_positive};
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access && !mapped;

  // Register writes
  always_comb
  begin
    driver_analog_settings_next = driver_analog_settings_reg;
    clock_divide_ratio_next = clock_divide_ratio_reg;
    pulse_width_next = pulse_width_reg;
    if (access && apb_req.pwrite)
    begin
      if (apb_req.paddr == ADDR_DRIVER)
        driver_analog_settings_next = 16'(merge({16'h0000, driver_analog_settings_reg},
                                                apb_req.pwdata, apb_req.pstrb) & 32'h00007FFF);
      if (apb_req.paddr == ADDR_DIVIDE)
        clock_divide_ratio_next = merge(clock_divide_ratio_reg, apb_req.pwdata, apb_req.pstrb);
      if (apb_req.paddr == ADDR_WIDTH)
        pulse_width_next = merge(pulse_width_reg, apb_req.pwdata, apb_req.pstrb);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      driver_analog_settings_reg <= `OCD_RST_DRIVER;
      clock_divide_ratio_reg <= `OCD_RST_DIVIDE;
      pulse_width_reg <= `OCD_RST_WIDTH;
    end
    else
    begin
      driver_analog_settings_reg <= driver_analog_settings_next;
      clock_divide_ratio_reg <= clock_divide_ratio_next;
      pulse_width_reg <= pulse_width_next;
    end
  end

  // Driver settings decode
  ocd_drive_type drive_next;
  always_comb
  begin
    drive_next.pad_regulator_select = 8'h01 <<
      driver_analog_settings_reg[`OCD_PAD_MSB:`OCD_PAD_LSB];
    drive_next.bias_resistor_enable =
      driver_analog_settings_reg[`OCD_BIAS_MSB:`OCD_BIAS_LSB] == `OCD_BIAS_ON_CODE;
    drive_next.regulator_level =
      driver_analog_settings_reg[`OCD_LEVEL_MSB:`OCD_LEVEL_LSB];
    drive_next.common_mode_level = cmos_format ? `OCD_CM_DEFAULT :
      driver_analog_settings_reg[`OCD_CM_MSB:`OCD_CM_LSB];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) drive_settings <= '{`OCD_RST_PAD_ONEHOT, 1'b0, 4'h0, 4'h0};
    else drive_settings <= drive_next;
  end

  // Period boundary: last cycle of a period, or every cycle in bypass
  assign boundary = bypass_reg || (32'(cnt_reg) >= act_div_reg - 32'h1);

  always_comb
  begin
    cnt_next = cnt_reg + CNT_W'(1);
    act_div_next = act_div_reg;
    act_wid_next = act_wid_reg;
    if (boundary)
    begin
      cnt_next = '0;
      act_div_next = clock_divide_ratio_reg;
      act_wid_next = clamp_width(clock_divide_ratio_reg, pulse_width_reg);
    end
    bypass_next = act_div_next <= 32'h1;
    full_next = 33'(cnt_next) < (act_wid_next >> 1);
    half_next = act_wid_next[0] && (33'(cnt_next) == (act_wid_next >> 1));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      act_div_reg <= `OCD_RST_DIVIDE;
      act_wid_reg <= {1'b0, `OCD_RST_WIDTH};
      bypass_reg <= 1'b0;
      full_reg <= 1'b1;
      half_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      act_div_reg <= act_div_next;
      act_wid_reg <= act_wid_next;
      bypass_reg <= bypass_next;
      full_reg <= full_next;
      half_reg <= half_next;
    end
  end

  // First-half level set at the rising edge, second-half level at the falling edge;
  // the clock never passes through gates, so no zero-width pulse at a half-cycle end
  always_comb
  begin
    rise_half_next = (full_next || half_next || bypass_next) ^ fall_half_reg;
    fall_half_next = (full_reg && !bypass_reg) ^ rise_half_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) rise_half_reg <= 1'b1;
    else rise_half_reg <= rise_half_next;
  end

  // Second half of each cycle, taken on the falling edge
  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n) fall_half_reg <= 1'b0;
    else fall_half_reg <= fall_half_next;
  end

  // Output: full cycles plus optional half, or the plain clock in bypass
  assign clock_out_positive = rise_half_reg ^ fall_half_reg;
  assign clock_out_negative = ~clock_out_positive;

  sequence s_boundary;
    !bypass_reg && boundary;
  endsequence

  chk_period_reload: assert property (@(posedge clk) disable iff (!rst_n)
    s_boundary |=> cnt_reg == '0) else $error("counter not reloaded at boundary");
  chk_ratio_latch: assert property (@(posedge clk) disable iff (!rst_n)
    s_boundary |=> act_div_reg == $past(clock_divide_ratio_reg))
    else $error("ratio not latched at boundary");
  chk_ratio_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !boundary |=> $stable(act_div_reg)) else $error("ratio changed mid period");
  chk_bypass_one: assert property (@(posedge clk) disable iff (!rst_n)
    act_div_reg == 32'h1 |-> bypass_reg) else $error("ratio one not bypassed");
  chk_pad_decode: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 drive_settings.pad_regulator_select ==
      (8'h01 << $past(driver_analog_settings_reg[`OCD_PAD_MSB:`OCD_PAD_LSB])))
    else $error("pad select decode wrong");
  chk_bias_code: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 drive_settings.bias_resistor_enable ==
      ($past(driver_analog_settings_reg[`OCD_BIAS_MSB:`OCD_BIAS_LSB]) == 4'h1))
    else $error("bias enable wrong");
  chk_level_pass: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 drive_settings.regulator_level ==
      $past(driver_analog_settings_reg[`OCD_LEVEL_MSB:`OCD_LEVEL_LSB]))
    else $error("regulator level wrong");
  chk_cmos_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    cmos_format |=> drive_settings.common_mode_level == 4'h0)
    else $error("common mode not ignored in CMOS");
  chk_width_high: assert property (@(posedge clk) disable iff (!rst_n)
    (s_boundary ##1 (!bypass_reg && act_wid_reg >= 33'h4)) |-> full_reg ##1 full_reg)
    else $error("high time too short");

endmodule // ocd_divider

// ==== tb/ocd_rx_model.sv ====
`timescale 1ns/1ps
// Far-end receiver: times the output clock
module ocd_rx_model (
  input wire logic clock_out_positive,
  input wire logic clock_out_negative,
  output logic [31:0] period_ps = 32'h0,
  output logic [31:0] high_ps = 32'h0,
  output logic [31:0] rise_count = 32'h0
);
  realtime last_rise = 0.0;
  // Rise to rise gives the period
  always @(posedge clock_out_positive)
  begin
    period_ps = $rtoi(($realtime - last_rise) * 1000.0);
    last_rise = $realtime;
    rise_count = rise_count + 32'h1;
  end
  // Rise to fall gives the high time
  always @(negedge clock_out_positive)
    high_ps = $rtoi(($realtime - last_rise) * 1000.0);
endmodule // ocd_rx_model

// ==== tb/ocd_divider_tb_top.sv ====
`timescale 1ns/1ps
`include "ocd_regs.svh"
module ocd_divider_tb_top
  import ocd_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, cmos_format = 1'b0, pready, pslverr, cpos, cneg;
  ocd_apb_req_type apb_req = '0;
  logic [31:0] prdata, period_ps, high_ps, rise_count, rd;
  logic err;
  ocd_drive_type drive_settings;
  int n_mismatch = 0, check_count = 0;
  always #12.5 clk = ~clk;
  ocd_divider i_dut (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmos_format(cmos_format),
    .drive_settings(drive_settings), .clock_out_positive(cpos), .clock_out_negative(cneg));
  ocd_rx_model i_rx (.clock_out_positive(cpos), .clock_out_negative(cneg),
    .period_ps(period_ps), .high_ps(high_ps), .rise_count(rise_count));
  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(logic wr, logic [13:0] idx, logic [31:0] wd);
    int i;
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd, 4'hF};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
    if (i == 16)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wait_rises(int n);
    logic [31:0] start = rise_count;
    int i;
    for (i = 0; i < 400 && rise_count - start < n; i++)
      @(posedge clk);
    if (i == 400)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic t_reset();
    apb(1'b0, `OCD_IDX_DRIVER, 32'h0);
    check("driver", rd, 32'h0);
    apb(1'b0, `OCD_IDX_DIVIDE, 32'h0);
    check("divide", rd, 32'h2);
  endtask
  // Fields decoded; common mode forced to 0 in CMOS
  task automatic t_driver();
    logic [15:0] w;
    for (int k = 0; k < 9; k++)
    begin
      cmos_format <= (k == 8);
      w = {1'b1, k[2:0], (k == 1) ? 4'h1 : {2'b00, k[1:0]}, k[3:0], 4'h5};
      if (k == 8)
        w[11:4] = 8'h00;
      apb(1'b1, `OCD_IDX_DRIVER, {16'h0, w});
      repeat (2) @(posedge clk);
      #1;
      check("pad", drive_settings.pad_regulator_select, 8'h01 << w[14:12]);
      check("bias", drive_settings.bias_resistor_enable, w[11:8] == 4'h1);
      check("level", drive_settings.regulator_level, w[7:4]);
      check("cm", drive_settings.common_mode_level, (k == 8) ? 4'h0 : 4'h5);
      apb(1'b0, `OCD_IDX_DRIVER, 32'h0);
      check("readback", rd, {17'h0, w[14:0]});
    end
  endtask
  // Ratio, width, bypass; ratio never zero
  task automatic t_clock();
    logic [31:0] tbl [5][4] = '{'{4, 3, 100000, 37500}, '{3, 2, 75000, 25000},
      '{1, 2, 25000, 12500}, '{5, 9, 125000, 112500}, '{2, 0, 50000, 25000}};
    foreach (tbl[i])
    begin
      apb(1'b1, `OCD_IDX_WIDTH, tbl[i][1]);
      apb(1'b1, `OCD_IDX_DIVIDE, tbl[i][0]);
      wait_rises(3);
      check("period", period_ps, tbl[i][2]);
      check("high", high_ps, tbl[i][3]);
      check("negative", cneg, !cpos);
    end
  endtask
  task automatic t_unmapped();
    apb(1'b1, 14'h0700, 32'hFFFF);
    check("werr", err, 1'b1);
    apb(1'b0, 14'h0700, 32'h0);
    check("rerr", err, 1'b1);
    check("rdata", rd, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_driver();
    t_clock();
    t_unmapped();
    test_done();
  end
endmodule // ocd_divider_tb_top
